// [design/asr_pkg.sv]
// constants and types for the asynchronous sram host controller
package asr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  // device timing figures in their own units
  localparam int READ_CYCLE_MIN_NS = 10;
  localparam int WRITE_CYCLE_MIN_NS = 10;
  localparam int WE_PULSE_MIN_NS = 7;
  localparam int DATA_SETUP_NS = 6;
  localparam int WE_HIGHZ_NS = 5;
  localparam int OE_DATA_VALID_NS = 5;
  localparam int FIRST_ACCESS_WAIT_US = 100;
  // least times round up to whole cycles, never below one
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int READ_CYCLE_MIN_CYC = ceil_cycles(READ_CYCLE_MIN_NS);
  localparam int WRITE_CYCLE_MIN_CYC = ceil_cycles(WRITE_CYCLE_MIN_NS);
  localparam int WE_PULSE_RAW = (WE_PULSE_MIN_NS > DATA_SETUP_NS +
    WE_HIGHZ_NS) ? WE_PULSE_MIN_NS : DATA_SETUP_NS + WE_HIGHZ_NS;
  localparam int WE_PULSE_CYC = ceil_cycles(WE_PULSE_RAW);
  localparam int FIRST_ACCESS_WAIT_CYC =
    ceil_cycles(FIRST_ACCESS_WAIT_US * 1000);
  localparam int CNT_W = 12;
  typedef enum logic [2:0] {
    ASR_POWER_WAIT, ASR_IDLE, ASR_SETUP, ASR_READ, ASR_WRITE,
    ASR_WRITE_END
  } asr_state_t;
endpackage

// [design/asr_sync.sv]
// two flip-flop synchroniser for the returned data bus
module asr_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  typedef struct packed {
    logic [15:0] stage1;
    logic [15:0] stage2;
  } asr_sync_t;
  asr_sync_t st;
  asr_sync_t next_st;
  always_comb begin
    next_st = st;
    next_st.stage1 = din;
    next_st.stage2 = st.stage1;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.stage2;
endmodule

// [design/asr_ctrl.sv]
// host controller driving an asynchronous 64k x 16 sram
//
// Behaviour
// - Writes need select, strobe and a lane low, all set before the start.
// - Write data is set up 6 ns before and held 0 ns after the write end.
// - Address is valid 7 ns before write end and 0 ns around start and end.
// - A strobe write with output enable low lasts data setup plus turn-off.
// - No access is made until 100 us after power is good.
// - Data comes 10 ns after the address; each read cycle lasts 10 ns.
// - Select is high before power drops; one read cycle after it returns. Here select goes high 3 clock edges after supply_good falls.
// - Write cycle 10 ns; strobe, select and lane low 7 ns before the end.
// - The write strobe stays high in every read cycle.
module asr_ctrl
  import asr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic supply_good,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asr_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
  output logic [asr_pkg::ADDR_W-1:0] mem_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic low_lane_enable_n,
  output logic high_lane_enable_n,
  output logic [asr_pkg::DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_n,
  input wire logic [asr_pkg::DATA_W-1:0] mem_dq_in
);
  import asr_pkg::*;

  localparam logic [CNT_W-1:0] WAIT_LOAD =
    CNT_W'(FIRST_ACCESS_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(READ_CYCLE_MIN_CYC + 1);
  localparam logic [CNT_W-1:0] WE_LOAD = CNT_W'(WE_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] WC_LOAD =
    CNT_W'(WRITE_CYCLE_MIN_CYC > WE_PULSE_CYC ?
           WRITE_CYCLE_MIN_CYC - WE_PULSE_CYC : 0);

  typedef struct packed {
    asr_state_t state;
    logic [CNT_W-1:0] count;
    logic pwr_s1;
    logic pwr_s2;
    logic is_write;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic lo_n;
    logic hi_n;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
  } asr_ctrl_t;

  asr_ctrl_t st;
  asr_ctrl_t next_st;
  logic [DATA_W-1:0] dq_sync;

  asr_sync u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .din(mem_dq_in),
    .dout(dq_sync)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.pwr_s1 = supply_good;
    next_st.pwr_s2 = st.pwr_s1;
    next_st.rsp_valid = 1'b0;
    if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
    case (st.state)
      ASR_POWER_WAIT: begin
        next_st.ready = 1'b0;
        if (!st.pwr_s2) begin
          next_st.count = WAIT_LOAD;
        end else if (st.count == '0) begin
          next_st.state = ASR_IDLE;
          next_st.ready = 1'b1;
        end
      end
      ASR_IDLE: begin
        if (req_valid && st.ready) begin
          next_st.addr = req_addr;
          next_st.is_write = req_write;
          next_st.lo_n = ~req_lanes[0];
          next_st.hi_n = ~req_lanes[1];
          next_st.dq_out = req_wdata;
          next_st.ready = 1'b0;
          next_st.state = ASR_SETUP;
        end
      end
      ASR_SETUP: begin
        next_st.cs_n = 1'b0;
        if (st.is_write) begin
          next_st.we_n = 1'b0;
          next_st.dq_oe_n = 1'b0;
          next_st.count = WE_LOAD;
          next_st.state = ASR_WRITE;
        end else begin
          next_st.oe_n = 1'b0;
          next_st.count = RD_LOAD;
          next_st.state = ASR_READ;
        end
      end
      // read cycle length plus sync delay
      ASR_READ: begin
        if (st.count == '0) begin
          next_st.rdata = dq_sync &
            {{8{~st.hi_n}}, {8{~st.lo_n}}};
          next_st.rsp_valid = 1'b1;
          next_st.cs_n = 1'b1;
          next_st.oe_n = 1'b1;
          next_st.lo_n = 1'b1;
          next_st.hi_n = 1'b1;
          next_st.ready = 1'b1;
          next_st.state = ASR_IDLE;
        end
      end
      ASR_WRITE: begin
        if (st.count == '0) begin
          next_st.we_n = 1'b1;
          next_st.count = WC_LOAD;
          next_st.state = ASR_WRITE_END;
        end
      end
      // data and address held after end
      ASR_WRITE_END: begin
        next_st.cs_n = 1'b1;
        next_st.lo_n = 1'b1;
        next_st.hi_n = 1'b1;
        next_st.dq_oe_n = 1'b1;
        if (st.count == '0) begin
          next_st.rsp_valid = 1'b1;
          next_st.ready = 1'b1;
          next_st.state = ASR_IDLE;
        end
      end
      default: begin
        next_st.state = ASR_POWER_WAIT;
      end
    endcase
    // deselect at once on supply loss
    if (!st.pwr_s2) begin
      next_st.state = ASR_POWER_WAIT;
      next_st.cs_n = 1'b1;
      next_st.we_n = 1'b1;
      next_st.oe_n = 1'b1;
      next_st.lo_n = 1'b1;
      next_st.hi_n = 1'b1;
      next_st.dq_oe_n = 1'b1;
      next_st.ready = 1'b0;
      next_st.count = WAIT_LOAD;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.state <= ASR_POWER_WAIT;
      st.count <= WAIT_LOAD;
      st.cs_n <= 1'b1;
      st.oe_n <= 1'b1;
      st.we_n <= 1'b1;
      st.lo_n <= 1'b1;
      st.hi_n <= 1'b1;
      st.dq_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign req_ready = st.ready;
  assign rsp_valid = st.rsp_valid;
  assign rsp_rdata = st.rdata;
  assign mem_addr = st.addr;
  assign chip_select_n = st.cs_n;
  assign output_enable_n = st.oe_n;
  assign write_strobe_n = st.we_n;
  assign low_lane_enable_n = st.lo_n;
  assign high_lane_enable_n = st.hi_n;
  assign mem_dq_out = st.dq_out;
  assign mem_dq_oe_n = st.dq_oe_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_WRITE_NEEDS_SELECT: assert property (@(posedge clock)
    disable iff (!reset_n) !write_strobe_n |-> !chip_select_n &&
      !mem_dq_oe_n && $stable(mem_addr))
    else $error("strobe low without select");
  // supply loss may drop every strobe at once
  AST_WRITE_ENDS_ON_STROBE: assert property (@(posedge clock)
    disable iff (!reset_n || !st.pwr_s1)
      $rose(write_strobe_n) |-> !chip_select_n)
    else $error("write not ended by strobe");
  AST_DATA_HELD: assert property (@(posedge clock)
    disable iff (!reset_n || !st.pwr_s1) $rose(write_strobe_n) |->
      !mem_dq_oe_n && $stable(mem_dq_out))
    else $error("data not held at write end");
  AST_ADDR_STABLE: assert property (@(posedge clock)
    disable iff (!reset_n) !chip_select_n && !$past(chip_select_n) |->
      $stable(mem_addr))
    else $error("address moved in access");
  AST_STROBE_WIDTH: assert property (@(posedge clock)
    disable iff (!reset_n || !st.pwr_s1) $fell(write_strobe_n) |->
      (!chip_select_n && !mem_dq_oe_n) [*2])
    else $error("strobe pulse not covered by select");
  AST_POWER_WAIT: assert property (@(posedge clock)
    disable iff (!reset_n) st.state == ASR_POWER_WAIT |->
      chip_select_n)
    else $error("access during power wait");
  AST_READ_STROBE_HIGH: assert property (@(posedge clock)
    disable iff (!reset_n) !output_enable_n |-> write_strobe_n)
    else $error("strobe low in read");
  AST_READ_LENGTH: assert property (@(posedge clock)
    disable iff (!reset_n || !st.pwr_s1) $fell(output_enable_n) |->
      !output_enable_n [*3])
    else $error("read cycle too short");
  AST_SUPPLY_DESELECT: assert property (@(posedge clock)
    disable iff (!reset_n) !st.pwr_s2 |=> chip_select_n)
    else $error("selected without supply");
  COV_READ: cover property (@(posedge clock) disable iff (!reset_n)
    rsp_valid && !st.is_write);
  COV_WRITE: cover property (@(posedge clock) disable iff (!reset_n)
    rsp_valid && st.is_write);
  COV_SUPPLY_LOSS: cover property (@(posedge clock)
    disable iff (!reset_n) $fell(st.pwr_s2));
endmodule

// [tb/asr_sram_model.sv]
// behavioural model of the 64k x 16 asynchronous sram
module asr_sram_model (
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic low_lane_enable_n,
  input wire logic high_lane_enable_n,
  input wire logic [15:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:65535];
  logic [15:0] noise = 16'hA55A;
  logic rd;
  // released lanes float to a pattern that changes every half cycle
  always #50 noise = {noise[14:0], ~noise[15]};
  assign rd = !chip_select_n && !output_enable_n && write_strobe_n;
  assign dout[7:0] = (rd && !low_lane_enable_n) ? mem[addr][7:0] : noise[7:0];
  assign dout[15:8] = (rd && !high_lane_enable_n) ? mem[addr][15:8]
    : noise[15:8];
  always @* begin
    if (!chip_select_n && !write_strobe_n) begin
      if (!low_lane_enable_n) mem[addr][7:0] = din[7:0];
      if (!high_lane_enable_n) mem[addr][15:8] = din[15:8];
    end
  end
endmodule

// [tb/test_asr_ctrl.sv]
// self-checking testbench of the sram host controller
module test_asr_ctrl import asr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // one read cycle plus two synchroniser stages
  localparam int READ_WIN = READ_CYCLE_MIN_CYC + 2;
  logic clock = 0, reset_n = 0, supply_good = 0;
  logic req_valid = 0, req_write = 0, req_ready, rsp_valid;
  logic [15:0] req_addr = 0, req_wdata = 0, rsp_rdata, mem_addr;
  logic [1:0] req_lanes = 0;
  logic chip_select_n, output_enable_n, write_strobe_n;
  logic low_lane_enable_n, high_lane_enable_n, mem_dq_oe_n;
  logic [15:0] mem_dq_out, mem_dq_in, sram_dq;
  logic [15:0] ref_mem [int];
  logic [15:0] a [8];
  logic [16:0] notes [$];
  logic [16:0] nt;
  int checks = 0, miscompares = 0, cycles = 0, n, rd_cnt = 0, we_cnt = 0;

  asr_ctrl u_asr_ctrl (.clock, .reset_n, .supply_good, .req_valid,
    .req_write, .req_addr, .req_wdata, .req_lanes, .req_ready, .rsp_valid,
    .rsp_rdata, .mem_addr, .chip_select_n, .output_enable_n,
    .write_strobe_n, .low_lane_enable_n, .high_lane_enable_n,
    .mem_dq_out, .mem_dq_oe_n, .mem_dq_in);
  asr_sram_model u_asr_sram_model (.chip_select_n, .output_enable_n,
    .write_strobe_n, .low_lane_enable_n, .high_lane_enable_n,
    .addr(mem_addr), .din(mem_dq_in), .dout(sram_dq));
  assign mem_dq_in = mem_dq_oe_n ? sram_dq : mem_dq_out;

  initial forever #50 clock = ~clock;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one request, noting its expected result
  task op(input logic w, input logic [15:0] ad, input logic [15:0] dt,
      input logic [1:0] ln);
    req_valid = 1;
    req_write = w;
    req_addr = ad;
    req_wdata = dt;
    req_lanes = ln;
    if (w) begin
      if (ln[0]) ref_mem[ad][7:0] = dt[7:0];
      if (ln[1]) ref_mem[ad][15:8] = dt[15:8];
      notes.push_back(17'h0);
    end else begin
      notes.push_back({1'b1, ln[1] ? ref_mem[ad][15:8] : 8'h00,
        ln[0] ? ref_mem[ad][7:0] : 8'h00});
    end
    while (req_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report;
    end
  end

  // ---------------------------------------------
  // monitor of the memory pins and responses
  // ---------------------------------------------
  always @(negedge clock) begin
    if (chip_select_n === 1'b1 && rsp_valid !== 1'b1) rd_cnt = 0;
    if (output_enable_n === 1'b0 && chip_select_n === 1'b0) rd_cnt++;
    if (output_enable_n === 1'b0) chk({15'h0, write_strobe_n}, 16'h1);
    if (write_strobe_n === 1'b0) begin
      we_cnt++;
      chk({14'h0, chip_select_n, mem_dq_oe_n}, 16'h0);
    end else if (we_cnt != 0) begin
      chk(16'(we_cnt), 16'(WE_PULSE_CYC));
      we_cnt = 0;
    end
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) chk(16'h1, 16'h0);
      else begin
        nt = notes.pop_front();
        if (nt[16]) begin
          chk(rsp_rdata, nt[15:0]);
          chk(16'(rd_cnt), 16'(READ_WIN));
        end
      end
    end
  end

  initial begin
    void'($urandom(32'hB9A2));
    req_valid = 1;
    repeat (2) @(negedge clock);
    reset_n = 1;
    supply_good = 1;
    repeat (500) @(negedge clock);
    req_valid = 0;
    n = 500;
    while (req_ready !== 1'b1) begin
      @(negedge clock);
      n++;
    end
    chk(16'(n >= FIRST_ACCESS_WAIT_CYC), 16'h1);
    for (int i = 0; i < 8; i++) begin
      a[i] = 16'($urandom);
      op(1, a[i], 16'($urandom), 2'h3);
    end
    for (int i = 0; i < 8; i++) op(1, a[i], 16'($urandom), 2'(i));
    for (int i = 0; i < 16; i++) op(0, a[i % 8], 16'h0, 2'(i));
    req_valid = 0;
    // supply loss in mid-read gives no response and deselects
    repeat (2) @(negedge clock);
    req_valid = 1;
    req_write = 0;
    req_addr = a[0];
    while (req_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    req_valid = 0;
    supply_good = 0;
    repeat (4) @(negedge clock);
    chk({15'h0, chip_select_n}, 16'h1);
    supply_good = 1;
    while (req_ready !== 1'b1) @(negedge clock);
    op(0, a[1], 16'h0, 2'h3);
    req_valid = 0;
    repeat (8) @(negedge clock);
    final_report;
  end
endmodule
